// ### hw/pcrs_core.sv
// Top: reset release sequencing and clock selection for the serial-link core
// Function
// RULE1 - Hard controller: pin reset resets core; app reset from status and clock-in-use.
// RULE2 - Soft controller: pin or power-on reset; power-on from pin or local reset.
// RULE3 - Hard controller for first/second rate, soft controller for third rate.
// RULE4 - After reset release, wait for fabric-clock-in-use before releasing more.
// RULE5 - Config and core soft reset release 32 cycles after clock-in-use.
// RULE6 - Then deassert the reset-state output to the application.
// RULE7 - Application reset deasserts 32 cycles after reset-state output releases.
// RULE8 - Receive PLL lock moves training from Detect.Quiet to Detect.Active.
// RULE9 - Receiver detected when status pulse arrives with receive status equal 3.
// RULE10 - After receiver detect, training moves from Detect.Active to Polling.Active.
// RULE11 - Receive PCS reset held until signal detect stable for 3 ms.
// RULE12 - After power-on reset deasserts, deassert transmit transceiver power-on reset.
// RULE13 - Transmit PCS reset released after transmit PLL lock stable 127 cycles.
// RULE14 - Link-side inputs cross into the core clock through synchronisers.
// RULE15 - PHY clock is 250, 500, 250 MHz for first, second, third rate.
// RULE16 - PHY clock may stop in 1 ms rate window; must be stable before expiry.
// RULE17 - Core clock and width stay at configured values after downtraining.
// RULE18 - Core clock 125 or 250 MHz, 62.5 MHz power saving for x1 first-rate 64-bit.
// RULE19 - 256-bit interface only with streaming interface, not memory-mapped.
// RULE20 - Fabric clock frequency never below core output clock frequency.
// RULE21 - System supplies 100 or 125 MHz reference within 300 PPM.
// RULE22 - Optional reconfiguration interface clocked between 50 and 125 MHz.
// RULE23 - Release counters count fabric cycles and restart on reset reassertion.
`timescale 1ns/1ps
module pcrs_core import pcrs_pkg::*; #(
  parameter int unsigned SIGDET_CYC = SIGDET_STABLE_CYC,
  parameter int unsigned RATE_CYC = RATE_WIN_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Reset sources
  input wire logic pin_rst_n,
  input wire logic local_rst_n,
  input wire logic clk_inuse,
  // Static configuration
  input wire pcrs_cfg_t cfg,
  // PHY status
  input wire pcrs_phy_t phy,
  input wire logic rate_change,
  input wire logic pclk_ok,
  // Reset outputs
  output logic por_n,
  output logic cfg_rst_n,
  output logic core_srst_n,
  output logic reset_state,
  output logic app_rst_n,
  output logic serdes_por_n,
  output logic rx_pcs_rst,
  output logic tx_pcs_rst,
  // Status
  output pcrs_lt_t lt_state,
  output logic rx_detected,
  output pcrs_clkinfo_t clkinfo,
  output logic rate_timeout
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] async_in;
  assign async_in = {pin_rst_n, local_rst_n, clk_inuse, rate_change, pclk_ok, phy.rx_pll_locked,
                     phy.tx_pll_locked, phy.rx_signaldetect, phy.phystatus, 1'b0};

  // Every link-side level is double-registered before use see RULE14
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  logic pin_s, local_s, inuse_s, rchg_s, pok_s, rxlock_s, txlock_s, sigdet_s, phys_s;
  assign {pin_s, local_s, inuse_s, rchg_s, pok_s, rxlock_s, txlock_s, sigdet_s, phys_s} = sync2_q[NSYNC-1:1];

  // Status field sampled with the synchronised pulse; held stable by the PHY around it
  logic [2:0] rxstat_q;
  logic [2:0] rxstat_s_q;
  logic phys_d_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxstat_q <= 3'h0;
      rxstat_s_q <= 3'h0;
      phys_d_q <= 1'b0;
    end else begin
      rxstat_q <= phy.rxstatus;
      rxstat_s_q <= rxstat_q;
      phys_d_q <= phys_s;
    end
  end

  // ****************************************
  // Controller choice and power-on reset
  // ****************************************
  logic soft_sel;
  assign soft_sel = (cfg.max_rate == GEN3); // see RULE3

  // Soft controller adds the local reset; hard uses the pin only see RULE1 see RULE2
  logic por_src;
  assign por_src = soft_sel ? (pin_s && local_s) : pin_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      por_n <= 1'b0;
      serdes_por_n <= 1'b0;
    end else begin
      por_n <= por_src;
      serdes_por_n <= por_n && por_src; // see RULE12
    end
  end

  // ****************************************
  // Core reset release sequence
  // ****************************************
  logic [5:0] rel_cnt_q;
  logic [5:0] app_cnt_q;

  // Counters clear whenever reset source drops see RULE23
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt_q <= 6'h00;
    end else if (!por_n || !inuse_s) begin
      rel_cnt_q <= 6'h00; // see RULE4
    end else if (rel_cnt_q != 6'(REL_DELAY_CYC)) begin
      rel_cnt_q <= rel_cnt_q + 6'h01;
    end
  end

  logic rel_now;
  assign rel_now = por_n && inuse_s && (rel_cnt_q == 6'(REL_DELAY_CYC));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rst_n <= 1'b0;
      core_srst_n <= 1'b0;
      reset_state <= 1'b1;
    end else begin
      cfg_rst_n <= rel_now; // see RULE5
      core_srst_n <= rel_now;
      reset_state <= !(cfg_rst_n && core_srst_n && rel_now); // see RULE6
    end
  end

  // Application reset follows reset-state output after 32 cycles see RULE7
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      app_cnt_q <= 6'h00;
      app_rst_n <= 1'b0;
    end else if (reset_state) begin
      app_cnt_q <= 6'h00;
      app_rst_n <= 1'b0;
    end else if (app_cnt_q != 6'(APP_DELAY_CYC - 1)) begin
      app_cnt_q <= app_cnt_q + 6'h01;
    end else begin
      app_rst_n <= 1'b1;
    end
  end

  // ****************************************
  // Link training front states
  // ****************************************
  logic det_hit;
  assign det_hit = phys_s && !phys_d_q && (rxstat_s_q == RXSTAT_DETECTED); // see RULE9

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lt_state <= PCRS_LT_QUIET;
      rx_detected <= 1'b0;
    end else if (!core_srst_n) begin
      lt_state <= PCRS_LT_QUIET;
      rx_detected <= 1'b0;
    end else begin
      unique case (lt_state)
        PCRS_LT_QUIET: begin
          if (rxlock_s) begin
            lt_state <= PCRS_LT_ACTIVE; // see RULE8
          end
        end
        PCRS_LT_ACTIVE: begin
          if (det_hit) begin
            rx_detected <= 1'b1;
            lt_state <= PCRS_LT_POLL; // see RULE10
          end
        end
        PCRS_LT_POLL: begin
          if (!rxlock_s) begin
            lt_state <= PCRS_LT_QUIET;
            rx_detected <= 1'b0;
          end
        end
        default: begin
          lt_state <= PCRS_LT_QUIET;
        end
      endcase
    end
  end

  // ****************************************
  // Transceiver PCS resets
  // ****************************************
  logic sig_ok;
  logic txlock_ok;

  pcrs_stable_timer #(.COUNT(SIGDET_CYC), .W(24)) u_sigdet (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(lt_state != PCRS_LT_POLL),
    .level(sigdet_s),
    .done(sig_ok)
  );

  pcrs_stable_timer #(.COUNT(TXPLL_STABLE_CYC), .W(8)) u_txlock (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(!serdes_por_n),
    .level(txlock_s),
    .done(txlock_ok)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pcs_rst <= 1'b1;
      tx_pcs_rst <= 1'b1;
    end else begin
      rx_pcs_rst <= !sig_ok; // see RULE11
      tx_pcs_rst <= !txlock_ok; // see RULE13
    end
  end

  // ****************************************
  // Clock selection and rate window
  // ****************************************
  // Chosen from configuration only, so downtraining never changes it see RULE17
  logic [1:0] core_sel;
  logic [1:0] wide_if;
  always_comb begin
    wide_if = (cfg.max_rate == GEN1) ? IFW_64 : ((cfg.max_rate == GEN2) ? IFW_128 : IFW_256);
    if (cfg.lanes == 4'h1 && cfg.max_rate == GEN1 && cfg.if_width == IFW_64 && cfg.power_save) begin
      core_sel = CLK_62M5; // see RULE18
    end else if (cfg.lanes == 4'h8 && cfg.max_rate != GEN3 && cfg.if_width == IFW_64) begin
      core_sel = CLK_250M;
    end else if (cfg.if_width < wide_if &&
                 (cfg.lanes >= 4'h4 || (cfg.lanes == 4'h2 && cfg.max_rate == GEN3 && cfg.if_width == IFW_64))) begin
      core_sel = CLK_250M;
    end else if (cfg.lanes == 4'h8 && cfg.if_width == wide_if && cfg.max_rate != GEN1) begin
      core_sel = CLK_250M;
    end else begin
      core_sel = CLK_125M;
    end
  end

  logic [RATE_WIN_MS*27-1:0] rate_cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkinfo <= '0;
      rate_cnt_q <= '0;
      rate_timeout <= 1'b0;
    end else begin
      clkinfo.coreclk_sel <= core_sel;
      clkinfo.pclk_sel <= (cfg.max_rate == GEN2) ? PCLK_500M : PCLK_250M; // see RULE15
      clkinfo.use_soft_ctrl <= soft_sel;
      clkinfo.cfg_error <= cfg.mm_variant && (cfg.if_width == IFW_256); // see RULE19
      // PHY clock must be back within the window see RULE16
      if (!rchg_s || pok_s) begin
        rate_cnt_q <= '0;
      end else if (rate_cnt_q != (RATE_WIN_MS*27)'(RATE_CYC)) begin
        rate_cnt_q <= rate_cnt_q + (RATE_WIN_MS*27)'(1);
      end
      rate_timeout <= rchg_s && !pok_s && (rate_cnt_q == (RATE_WIN_MS*27)'(RATE_CYC));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_app_after_state: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE7
    $fell(reset_state) |-> (!app_rst_n && !reset_state) [*8] ##25 app_rst_n)
    else $error("application reset not released 32 cycles after reset state");

  chk_rel_delay: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE5
    $rose(cfg_rst_n) |-> $past(rel_cnt_q) == 6'(REL_DELAY_CYC) && core_srst_n)
    else $error("config reset released at wrong count");

  chk_wait_inuse: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
    !inuse_s |=> !cfg_rst_n)
    else $error("release without clock in use");

  chk_state_order: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
    $fell(reset_state) |-> cfg_rst_n && core_srst_n)
    else $error("reset state dropped before core resets");

  chk_det_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE8
    lt_state == PCRS_LT_QUIET && rxlock_s && core_srst_n |=> lt_state == PCRS_LT_ACTIVE)
    else $error("training did not leave quiet on lock");

  chk_det_poll: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE10
    lt_state == PCRS_LT_ACTIVE && det_hit && core_srst_n |=> lt_state == PCRS_LT_POLL && rx_detected)
    else $error("training did not advance on receiver detect");

  chk_det_code: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE9
    $rose(rx_detected) |-> $past(rxstat_s_q) == RXSTAT_DETECTED)
    else $error("detect with wrong receive status");

  chk_tx_lock: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE13
    $fell(tx_pcs_rst) |-> $past(txlock_s, 8))
    else $error("transmit PCS reset released without stable lock");

  chk_rx_sig: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE11
    !sigdet_s |=> ##1 rx_pcs_rst)
    else $error("receive PCS reset out of reset without signal");

  chk_serdes_por: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE12
    !por_n |=> !serdes_por_n)
    else $error("transmit power-on reset released before core");

endmodule : pcrs_core

// ### hw/pcrs_stable_timer.sv
// Stability timer: output rises once input has held high for a count
`timescale 1ns/1ps
module pcrs_stable_timer import pcrs_pkg::*; #(
  parameter int unsigned COUNT = 32,
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Restart and level
  input wire logic clr,
  input wire logic level,
  output logic done
);

  // ****************************************
  // Counter
  // ****************************************
  logic [W-1:0] cnt_q;

  // Any drop of level restarts the count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (clr || !level) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (cnt_q == W'(COUNT - 1)) begin
      done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

endmodule : pcrs_stable_timer

// ### shared/pcrs_pkg.sv
// Package: constants and carriers for the core reset and clock sequencer
package pcrs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned REL_DELAY_CYC = 32;
  localparam int unsigned APP_DELAY_CYC = 32;
  localparam int unsigned TXPLL_STABLE_CYC = 127;
  localparam int unsigned SIGDET_STABLE_MS = 3;
  localparam int unsigned SIGDET_STABLE_CYC = SIGDET_STABLE_MS * CLK_MHZ * 1000;
  localparam int unsigned RATE_WIN_MS = 1;
  localparam int unsigned RATE_WIN_CYC = RATE_WIN_MS * CLK_MHZ * 1000;

  // ****************************************
  // Receiver detect encoding
  // ****************************************
  localparam logic [2:0] RXSTAT_DETECTED = 3'h3;

  // ****************************************
  // Configuration encodings
  // ****************************************
  localparam logic [1:0] GEN1 = 2'h0;
  localparam logic [1:0] GEN2 = 2'h1;
  localparam logic [1:0] GEN3 = 2'h2;
  localparam logic [1:0] IFW_64 = 2'h0;
  localparam logic [1:0] IFW_128 = 2'h1;
  localparam logic [1:0] IFW_256 = 2'h2;
  localparam logic [1:0] CLK_62M5 = 2'h0;
  localparam logic [1:0] CLK_125M = 2'h1;
  localparam logic [1:0] CLK_250M = 2'h2;
  localparam logic [1:0] PCLK_250M = 2'h0;
  localparam logic [1:0] PCLK_500M = 2'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PCRS_LT_QUIET = 2'h0,
    PCRS_LT_ACTIVE = 2'h1,
    PCRS_LT_POLL = 2'h2
  } pcrs_lt_t;

  typedef struct packed {
    logic [1:0] max_rate;
    logic [3:0] lanes;
    logic [1:0] if_width;
    logic mm_variant;
    logic power_save;
  } pcrs_cfg_t;

  typedef struct packed {
    logic [1:0] coreclk_sel;
    logic [1:0] pclk_sel;
    logic use_soft_ctrl;
    logic cfg_error;
  } pcrs_clkinfo_t;

  typedef struct packed {
    logic rx_pll_locked;
    logic tx_pll_locked;
    logic rx_signaldetect;
    logic phystatus;
    logic [2:0] rxstatus;
  } pcrs_phy_t;

endpackage : pcrs_pkg

// ### verification/pcrs_phy_model.sv
// PHY partner model: lock, signal detect and receiver detect pulse
`timescale 1ns/1ps
module pcrs_phy_model import pcrs_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench controls
  input wire logic rx_lock,
  input wire logic tx_lock,
  input wire logic sig_det,
  input wire logic det_go,
  input wire logic [2:0] det_stat,
  // Toward the sequencer
  output pcrs_phy_t phy
);
  logic [2:0] st_q;
  logic [2:0] stat_q;
  logic [2:0] noise_q;

  // Status set a cycle early, four-cycle pulse, held two more
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= 3'h0;
      stat_q <= 3'h0;
    end else if (det_go && st_q == 3'h0) begin
      st_q <= 3'h1;
      stat_q <= det_stat;
    end else if (st_q != 3'h0) begin
      st_q <= st_q + 3'h1;
    end
  end

  // Status is never steady while no detect sequence is running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      noise_q <= 3'h0;
    end else begin
      noise_q <= noise_q + 3'h5;
    end
  end

  assign phy.rx_pll_locked = rx_lock;
  assign phy.tx_pll_locked = tx_lock;
  assign phy.rx_signaldetect = sig_det;
  assign phy.phystatus = (st_q >= 3'h2) && (st_q <= 3'h5);
  assign phy.rxstatus = (st_q != 3'h0) ? stat_q : noise_q;
endmodule : pcrs_phy_model

// ### verification/tb_top.sv
// Testbench: reset order, transceiver resets, training and clock table
`timescale 1ns/1ps
module tb_top import pcrs_pkg::*; ;
  localparam int unsigned SD_CYC = 50;
  localparam int unsigned RC_CYC = 40;
  logic mclk, rst_n, pin_rst_n, local_rst_n, clk_inuse, rate_change, pclk_ok;
  logic rx_lock, tx_lock, sig_det, det_go;
  logic [2:0] det_stat;
  pcrs_cfg_t cfg;
  pcrs_phy_t phy;
  logic por_n, cfg_rst_n, core_srst_n, reset_state, app_rst_n, serdes_por_n;
  logic rx_pcs_rst, tx_pcs_rst, rx_detected, rate_timeout;
  pcrs_lt_t lt_state;
  pcrs_clkinfo_t clkinfo;
  int err_count, tests_run, cyc, n;
  pcrs_cfg_t c;
  logic [2:0] s;

  pcrs_core #(.SIGDET_CYC(SD_CYC), .RATE_CYC(RC_CYC)) DUT (.mclk(mclk), .rst_n(rst_n),
    .pin_rst_n(pin_rst_n), .local_rst_n(local_rst_n), .clk_inuse(clk_inuse), .cfg(cfg), .phy(phy),
    .rate_change(rate_change), .pclk_ok(pclk_ok), .por_n(por_n), .cfg_rst_n(cfg_rst_n),
    .core_srst_n(core_srst_n), .reset_state(reset_state), .app_rst_n(app_rst_n),
    .serdes_por_n(serdes_por_n), .rx_pcs_rst(rx_pcs_rst), .tx_pcs_rst(tx_pcs_rst),
    .lt_state(lt_state), .rx_detected(rx_detected), .clkinfo(clkinfo), .rate_timeout(rate_timeout));

  pcrs_phy_model PHY (.mclk(mclk), .rst_n(rst_n), .rx_lock(rx_lock), .tx_lock(tx_lock),
    .sig_det(sig_det), .det_go(det_go), .det_stat(det_stat), .phy(phy));

  // One 125 MHz clock stands in for fabric, reference and reconfiguration clocks
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ********
  // Helpers
  // ********
  task tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng

  function automatic logic sel(input int w);
    case (w)
      0: return cfg_rst_n;
      1: return reset_state;
      2: return app_rst_n;
      3: return tx_pcs_rst;
      default: return rx_pcs_rst;
    endcase
  endfunction : sel

  // Cycles from the last drive edge until the output reaches v
  task wcnt(input int w, input logic v, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (sel(w) !== v && k < 400);
  endtask : wcnt

  task detect(input logic [2:0] v);
    tick(1);
    det_go <= 1'b1;
    det_stat <= v;
    tick(1);
    det_go <= 1'b0;
    tick(14);
    #1;
  endtask : detect

  function automatic int kval(input pcrs_cfg_t x);
    int g;
    g = (x.max_rate == GEN1) ? 1 : (x.max_rate == GEN2) ? 2 : 4;
    return int'(x.lanes) * g * 64 / ((x.if_width == IFW_64) ? 64 : (x.if_width == IFW_128) ? 128 : 256);
  endfunction : kval

  function automatic pcrs_clkinfo_t exp_info(input pcrs_cfg_t x);
    pcrs_clkinfo_t e;
    e.coreclk_sel = x.power_save ? CLK_62M5 : (kval(x) == 8) ? CLK_250M : CLK_125M;
    e.pclk_sel = (x.max_rate == GEN2) ? PCLK_500M : PCLK_250M;
    e.use_soft_ctrl = (x.max_rate == GEN3);
    e.cfg_error = x.mm_variant && (x.if_width == IFW_256);
    return e;
  endfunction : exp_info

  task finish_test;
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Hang guard, far above the fewer than a thousand cycles used
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ********
  // Sequence
  // ********
  initial begin
    {rst_n, pin_rst_n, local_rst_n, clk_inuse, rate_change, pclk_ok} = 6'h09;
    {rx_lock, tx_lock, sig_det, det_go, det_stat} = 7'h00;
    cfg = '{max_rate: GEN1, lanes: 4'h1, if_width: IFW_64, mm_variant: 1'b0, power_save: 1'b0};
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(16));
    tick(4);
    #1;
    chk({por_n, cfg_rst_n, core_srst_n, reset_state, app_rst_n, serdes_por_n}, 6'h04);
    chk({rx_pcs_rst, tx_pcs_rst, lt_state, rx_detected, rate_timeout}, 6'h30);
    tick(1);
    rst_n <= 1'b1;
    tick(1);
    pin_rst_n <= 1'b1;
    tick(10 + $urandom % 30);
    #1;
    chk(cfg_rst_n, 1'b0);
    // Abort the count part way; it has to start again
    tick(1);
    clk_inuse <= 1'b1;
    tick(10);
    clk_inuse <= 1'b0;
    tick(5);
    clk_inuse <= 1'b1;
    wcnt(0, 1'b1, n);
    rng(n, 32, 37);
    chk({core_srst_n, reset_state, app_rst_n}, 3'h6);
    wcnt(1, 1'b0, n);
    rng(n, 1, 1);
    wcnt(2, 1'b1, n);
    rng(n, 32, 32);
    chk({serdes_por_n, tx_pcs_rst}, 2'h3);
    tick(1);
    tx_lock <= 1'b1;
    tick(20);
    tx_lock <= 1'b0;
    tick(1);
    tx_lock <= 1'b1;
    wcnt(3, 1'b0, n);
    rng(n, 127, 134);
    tick(1);
    rx_lock <= 1'b1;
    tick(6);
    #1;
    chk(lt_state, PCRS_LT_ACTIVE);
    // Every status code, the detected one last
    for (int i = 0; i < 8; i++) begin
      s = 3'(i + 4);
      tick($urandom % 5);
      detect(s);
      chk(lt_state, (s == 3'h3) ? PCRS_LT_POLL : PCRS_LT_ACTIVE);
      chk(rx_detected, s == RXSTAT_DETECTED);
    end
    chk(rx_pcs_rst, 1'b1);
    tick(1);
    sig_det <= 1'b1;
    tick(20);
    sig_det <= 1'b0;
    tick(1);
    sig_det <= 1'b1;
    wcnt(4, 1'b0, n);
    rng(n, SD_CYC, SD_CYC + 6);
    tick(1);
    rx_lock <= 1'b0;
    tick(6);
    #1;
    chk(lt_state, PCRS_LT_QUIET);
    tick(1);
    rate_change <= 1'b1;
    pclk_ok <= 1'b0;
    tick(RC_CYC - 10);
    #1;
    chk(rate_timeout, 1'b0);
    tick(20);
    #1;
    chk(rate_timeout, 1'b1);
    tick(1);
    pclk_ok <= 1'b1;
    rate_change <= 1'b0;
    tick(6);
    #1;
    chk(rate_timeout, 1'b0);
    // Local reset counts only under the third-rate controller
    tick(1);
    local_rst_n <= 1'b0;
    tick(8);
    #1;
    chk(por_n, 1'b1);
    tick(1);
    cfg.max_rate <= GEN3;
    tick(8);
    #1;
    chk({por_n, cfg_rst_n, app_rst_n}, 3'h0);
    tick(1);
    local_rst_n <= 1'b1;
    wcnt(0, 1'b1, n);
    rng(n, 33, 40);
    // Listed configurations only; power saving only on its one row
    for (int r = 0; r < 3; r++)
      for (int li = 0; li < 4; li++)
        for (int w = 0; w < 3; w++)
          for (int p = 0; p < 2; p++) begin
            c = '{max_rate: 2'(r), lanes: 4'(1 << li), if_width: 2'(w), mm_variant: 1'($urandom % 2),
              power_save: 1'(p)};
            if (kval(c) < 1 || kval(c) > 8 || (w != 0 && kval(c) < 4)) continue;
            if (p == 1 && (r != 0 || li != 0 || w != 0)) continue;
            tick(1);
            cfg <= c;
            tick(4);
            #1;
            chk(clkinfo.cfg_error, exp_info(c).cfg_error);
            if (!exp_info(c).cfg_error)
              chk(clkinfo, exp_info(c));
          end
    finish_test();
  end
endmodule : tb_top
